// *** design/sph_regs.svh ***
// register offsets, field positions, reset values and timing counts
// of the serial peripheral host/client; included by the design files
`ifndef SPH_REGS_SVH
`define SPH_REGS_SVH

// byte offsets on the register bus
`define SPH_OFS_CTRLA   8'h00
`define SPH_OFS_CTRLB   8'h04
`define SPH_OFS_BAUD    8'h08
`define SPH_OFS_ADDR    8'h0c
`define SPH_OFS_DATA    8'h10
`define SPH_OFS_STATUS  8'h14

// control a fields
`define SPH_CA_EN       0
`define SPH_CA_MODE     2
`define SPH_CA_CLOCK_POLARITY_SELECT     4
`define SPH_CA_CLOCK_PHASE_SELECT     5
`define SPH_CA_LSB      6
`define SPH_CA_DATA_IN_PAD_SELECT     8
`define SPH_CA_DATA_OUT_PAD_SELECT     10

// control b fields
`define SPH_CB_RXEN     0
`define SPH_CB_HOST_SELECT_AUTO_ENABLE    1
`define SPH_CB_AMEN     2
`define SPH_CB_TXDIS    3
`define SPH_CB_SSSW     4
`define SPH_CB_RESET    5'h10

// status fields
`define SPH_ST_DRE      0
`define SPH_ST_TXC      1
`define SPH_ST_RXC      2
`define SPH_ST_OVF      3
`define SPH_ST_AMATCH   4
`define SPH_ST_SSCHG    5
`define SPH_ST_SYNCBSY  6

// operating modes
`define SPH_MODE_HOST   2'h3
`define SPH_MODE_CLIENT 2'h2

// cycles before a control b write takes effect
`define SPH_SYNC_CYCLES 2'h3

// bus responses
`define SPH_RESP_OKAY   2'h0
`define SPH_RESP_SLVERR 2'h2

`endif

// *** design/sph_pkg.sv ***
// types shared by the serial peripheral host/client design
// assumes nothing of its surroundings
package sph_pkg;

  // host sequencer states, gray coded along idle, shift, done
  typedef enum logic [1:0] {
    SPH_IDLE  = 2'b00,
    SPH_SHIFT = 2'b01,
    SPH_DONE  = 2'b11
  } sph_state_t;

endpackage

// *** design/sph_top.sv ***
// four-wire serial peripheral, host or client, behind an axi4-lite slave
// assumes one 40 MHz clock; pad inputs already synchronous to it
//
// Notes on behaviour
// RQ1 - full duplex over four wires
// RQ2 - one transmit buffer, two receive entries
// RQ3 - all four polarity/phase modes
// RQ4 - unused data-out line released when disabled
// RQ5 - software picks lsb or msb first
// RQ6 - serial clock at most half system clock
// RQ7 - host clock from 8-bit baud divider
// RQ8 - automatic select drives select line in host
// RQ9 - client optionally matches an 8-bit address
// RQ10 - client keeps working in every sleep mode
// RQ11 - client wakes system on select change
// RQ12 - pin directions follow host or client role
// RQ13 - disabled receiver leaves data-in pin unused
// RQ14 - pad-select fields map signals onto pads
// RQ15 - keeps running asleep; events can wake
// RQ16 - control b writes pass synchroniser first
// RQ17 - request lines for dma service
// RQ18 - mode 0x3 is host
// RQ19 - mode 0x2 is client from pin clock
// RQ20 - launch one edge, sample the other
// RQ21 - host lowers select to frame transfers
`timescale 1ns/1ps
`include "sph_regs.svh"

module sph_top #(
  parameter int RX_DEPTH = 2
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic [3:0]  PAD_I,
  output logic [3:0]       PAD_O,
  output logic [3:0]       PAD_OE_O,
  input  wire logic        SLEEP_I,
  output logic             WAKE_O,
  output logic             DMA_TX_REQ_O,
  output logic             DMA_RX_REQ_O
);

  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int PW = $clog2(RX_DEPTH);

  // every property below samples on the system clock and rests during reset
  default clocking cb_main @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  // bit order swap, used on transmit load and receive unload
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // pad index for data-out (0), clock (1) and select (2) per layout
  function automatic logic [1:0] pad_of(input logic [1:0] data_out_pad_select, input logic [1:0] sig);
    logic [1:0] p;
    p = 2'h0;
    case ({data_out_pad_select, sig})
      4'h0: p = 2'h0;
      4'h1: p = 2'h1;
      4'h2: p = 2'h2;
      4'h4: p = 2'h2;
      4'h5: p = 2'h3;
      4'h6: p = 2'h1;
      4'h8: p = 2'h3;
      4'h9: p = 2'h1;
      4'ha: p = 2'h2;
      4'hc: p = 2'h0;
      4'hd: p = 2'h3;
      4'he: p = 2'h1;
      default: p = 2'h0;
    endcase
    return p;
  endfunction

  logic              en_r, clock_polarity_select_r, clock_phase_select_r, lsb_r;
  logic [1:0]        mode_r, data_in_pad_select_r, data_out_pad_select_r;
  logic [4:0]        ctrlb_r, pend_r;
  logic [1:0]        sync_cnt_r;
  logic [7:0]        baud_r, addr_r;
  logic              aw_got_r, w_got_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic [7:0]        tx_buf_r, tx_sh_r, rx_sh_r;
  logic              tx_valid_r;
  logic [7:0]        rx_mem [RX_DEPTH];
  logic [PW-1:0]     wr_ptr_r, rd_ptr_r;
  logic [CW-1:0]     rx_cnt_r;
  logic              txc_r, ovf_r, amatch_r, sschg_r;
  sph_pkg::sph_state_t state_r;
  logic [7:0]        div_cnt_r;
  logic [3:0]        edge_cnt_r;
  logic              sck_r, ss_auto_r, sck_q_r, ss_q_r, addr_ph_r, drop_r;
  logic [3:0]        pad_o_nxt, pad_oe_nxt;
  logic [31:0]       rd_val;

  // role decode and pad mapping
  logic is_host, is_client, rxen, host_select_auto_enable, amen, txdis, sync_busy;
  logic [1:0] do_pad, sck_pad, ss_pad;
  logic sck_in, ss_in, din, ss_lvl;
  assign rxen      = ctrlb_r[`SPH_CB_RXEN];
  assign host_select_auto_enable     = ctrlb_r[`SPH_CB_HOST_SELECT_AUTO_ENABLE];
  assign amen      = ctrlb_r[`SPH_CB_AMEN];
  assign txdis     = ctrlb_r[`SPH_CB_TXDIS];
  assign sync_busy = sync_cnt_r != 2'h0;
  // RQ18 host mode code
  assign is_host   = en_r && mode_r == `SPH_MODE_HOST;
  // RQ19 client mode code
  assign is_client = en_r && mode_r == `SPH_MODE_CLIENT;
  // RQ14 pad selection
  assign do_pad    = pad_of(data_out_pad_select_r, 2'h0);
  assign sck_pad   = pad_of(data_out_pad_select_r, 2'h1);
  assign ss_pad    = pad_of(data_out_pad_select_r, 2'h2);
  assign sck_in    = PAD_I[sck_pad];
  assign ss_in     = PAD_I[ss_pad];
  // RQ13 receiver off ignores pin
  assign din       = rxen & PAD_I[data_in_pad_select_r];
  // RQ8 hardware or software select
  assign ss_lvl    = host_select_auto_enable ? ss_auto_r : ctrlb_r[`SPH_CB_SSSW];

  // edge engine shared by both roles
  logic tick, host_edge, cli_edge, edge_ev, lead, smp, stp, char_done;
  logic host_start, ss_fall, load_ev, take, push, pop;
  logic [7:0] rx_word, rx_char;
  assign tick       = div_cnt_r == baud_r;
  assign host_edge  = is_host && state_r == sph_pkg::SPH_SHIFT && tick;
  // RQ10 client runs from pin clock, sleep not gated
  assign cli_edge   = is_client && !ss_in && sck_in != sck_q_r;
  assign edge_ev    = host_edge | cli_edge;
  assign lead       = is_host ? (sck_r == clock_polarity_select_r) : (sck_in != clock_polarity_select_r);
  // RQ20 sample on one edge, launch on the other
  assign smp        = edge_ev && (lead ^ clock_phase_select_r);
  assign stp        = edge_ev && !(lead ^ clock_phase_select_r) && edge_cnt_r != 4'h0;
  assign char_done  = edge_ev && edge_cnt_r == 4'hf;
  assign rx_word    = clock_phase_select_r ? {rx_sh_r[6:0], din} : rx_sh_r;
  // RQ5 bit order on receive
  assign rx_char    = lsb_r ? rev8(rx_word) : rx_word;
  assign host_start = is_host && state_r == sph_pkg::SPH_IDLE && tx_valid_r;
  assign ss_fall    = is_client && ss_q_r && !ss_in;
  assign load_ev    = host_start || ss_fall || (char_done && (is_client || tx_valid_r));
  assign take       = load_ev && tx_valid_r;
  // RQ9 address character and dropped frames are not stored
  assign push       = char_done && rxen && !(is_client && (addr_ph_r || drop_r));

  // bus write decode
  logic wr_fire, wr_ok, wr_lo, ar_fire, data_wr;
  assign wr_fire = aw_got_r && w_got_r && !S_AXI_BVALID_O;
  assign wr_lo   = wstrb_r[0];
  assign wr_ok   = awaddr_r == `SPH_OFS_CTRLA || awaddr_r == `SPH_OFS_BAUD ||
                   awaddr_r == `SPH_OFS_ADDR || awaddr_r == `SPH_OFS_DATA ||
                   awaddr_r == `SPH_OFS_STATUS ||
                   (awaddr_r == `SPH_OFS_CTRLB && !sync_busy);
  assign data_wr = wr_fire && wr_ok && wr_lo && awaddr_r == `SPH_OFS_DATA;
  assign ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign pop     = ar_fire && S_AXI_ARADDR_I == `SPH_OFS_DATA && rx_cnt_r != '0;

  // write channel: address and data taken in either order
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_got_r <= 1'b0; w_got_r <= 1'b0; awaddr_r <= 8'h00; wdata_r <= 32'h0;
      wstrb_r <= 4'h0; S_AXI_AWREADY_O <= 1'b1; S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0; S_AXI_BRESP_O <= `SPH_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_got_r <= 1'b1; awaddr_r <= S_AXI_AWADDR_I; S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_got_r <= 1'b1; wdata_r <= S_AXI_WDATA_I; wstrb_r <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_ok ? `SPH_RESP_OKAY : `SPH_RESP_SLVERR;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0; aw_got_r <= 1'b0; w_got_r <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1; S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0;
    case (S_AXI_ARADDR_I)
      `SPH_OFS_CTRLA:  rd_val = {20'h0, data_out_pad_select_r, data_in_pad_select_r, 1'b0, lsb_r, clock_phase_select_r, clock_polarity_select_r,
                                 mode_r, 1'b0, en_r};
      `SPH_OFS_CTRLB:  rd_val = {27'h0, ctrlb_r};
      `SPH_OFS_BAUD:   rd_val = {24'h0, baud_r};
      `SPH_OFS_ADDR:   rd_val = {24'h0, addr_r};
      `SPH_OFS_DATA:   rd_val = {24'h0, rx_mem[rd_ptr_r]};
      `SPH_OFS_STATUS: rd_val = {25'h0, sync_busy, sschg_r, amatch_r, ovf_r,
                                 rx_cnt_r != '0, txc_r, !tx_valid_r};
      default:         rd_val = 32'h0;
    endcase
  end

  // read channel: one cycle from address to data
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      S_AXI_ARREADY_O <= 1'b1; S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0; S_AXI_RRESP_O <= `SPH_RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_ARREADY_O <= 1'b0; S_AXI_RVALID_O <= 1'b1; S_AXI_RDATA_O <= rd_val;
      S_AXI_RRESP_O <= (S_AXI_ARADDR_I > `SPH_OFS_STATUS || S_AXI_ARADDR_I[1:0] != 2'h0) ?
                       `SPH_RESP_SLVERR : `SPH_RESP_OKAY;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0; S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // control a, baud, address: layout fields locked while enabled
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      en_r <= 1'b0; mode_r <= 2'h0; clock_polarity_select_r <= 1'b0; clock_phase_select_r <= 1'b0; lsb_r <= 1'b0;
      data_in_pad_select_r <= 2'h0; data_out_pad_select_r <= 2'h0; baud_r <= 8'h00; addr_r <= 8'h00;
    end else if (wr_fire && wr_lo) begin
      if (awaddr_r == `SPH_OFS_CTRLA) begin
        en_r <= wdata_r[`SPH_CA_EN];
        if (!en_r) begin
          mode_r <= wdata_r[`SPH_CA_MODE +: 2];
          // RQ3 polarity and phase select
          clock_polarity_select_r <= wdata_r[`SPH_CA_CLOCK_POLARITY_SELECT];
          clock_phase_select_r <= wdata_r[`SPH_CA_CLOCK_PHASE_SELECT];
          lsb_r  <= wdata_r[`SPH_CA_LSB];
          if (wstrb_r[1]) begin
            data_in_pad_select_r <= wdata_r[`SPH_CA_DATA_IN_PAD_SELECT +: 2];
            data_out_pad_select_r <= wdata_r[`SPH_CA_DATA_OUT_PAD_SELECT +: 2];
          end
        end
      end
      // RQ7 8-bit divider setting
      if (awaddr_r == `SPH_OFS_BAUD && !en_r) baud_r <= wdata_r[7:0];
      if (awaddr_r == `SPH_OFS_ADDR && !en_r) addr_r <= wdata_r[7:0];
    end
  end

  // RQ16 control b lands only after the sync delay
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrlb_r <= `SPH_CB_RESET; pend_r <= `SPH_CB_RESET; sync_cnt_r <= 2'h0;
    end else if (wr_fire && wr_ok && wr_lo && awaddr_r == `SPH_OFS_CTRLB) begin
      pend_r <= wdata_r[4:0]; sync_cnt_r <= `SPH_SYNC_CYCLES;
    end else if (sync_busy) begin
      sync_cnt_r <= sync_cnt_r - 2'h1;
      if (sync_cnt_r == 2'h1) ctrlb_r <= pend_r;
    end
  end
  // RQ16 busy then applied
  AST_SYNC_DELAY: assert property (                                        // RQ16
    (wr_fire && wr_ok && wr_lo && awaddr_r == `SPH_OFS_CTRLB)
      |=> sync_busy [*3] ##1 (!sync_busy && ctrlb_r == $past(pend_r)))
    else $error("control b not applied after sync delay");

  // RQ2 single transmit buffer
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_buf_r <= 8'h00; tx_valid_r <= 1'b0;
    end else if (data_wr) begin
      tx_buf_r <= wdata_r[7:0]; tx_valid_r <= 1'b1;
    end else if (take || !en_r) begin
      tx_valid_r <= 1'b0;
    end
  end
  // the dma request reads the full buffer one registered cycle later
  AST_TX_BUF_FULL: assert property (data_wr |=> tx_valid_r ##1 !DMA_TX_REQ_O) // RQ2
    else $error("transmit buffer not marked full after write");

  // RQ2 two-entry receive buffer; overflow drops the new char
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_ptr_r <= '0; rd_ptr_r <= '0; rx_cnt_r <= '0;
    end else begin
      if (push && (rx_cnt_r != CW'(RX_DEPTH) || pop)) begin
        rx_mem[wr_ptr_r] <= rx_char;
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && rx_cnt_r != CW'(RX_DEPTH) && !pop) rx_cnt_r <= rx_cnt_r + 1'b1;
      else if (pop && !push) rx_cnt_r <= rx_cnt_r - 1'b1;
    end
  end
  AST_RX_BOUND: assert property (rx_cnt_r <= CW'(RX_DEPTH))              // RQ2
    else $error("receive buffer count above depth");
  // RQ13 nothing stored while receiver off
  AST_RX_OFF: assert property (!rxen && !pop |=> rx_cnt_r == $past(rx_cnt_r)) // RQ13
    else $error("character stored with receiver disabled");

  // sticky status; a set in the clearing cycle wins
  logic clr_st, txc_set;
  assign clr_st  = wr_fire && wr_lo && awaddr_r == `SPH_OFS_STATUS;
  assign txc_set = (is_host && state_r == sph_pkg::SPH_DONE && tick) ||
                   (is_client && char_done && !tx_valid_r);
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      txc_r <= 1'b0; ovf_r <= 1'b0; amatch_r <= 1'b0; sschg_r <= 1'b0;
    end else begin
      txc_r <= txc_set | (txc_r & ~data_wr & ~(clr_st & wdata_r[`SPH_ST_TXC]));
      ovf_r <= (push && rx_cnt_r == CW'(RX_DEPTH) && !pop) |
               (ovf_r & ~(clr_st & wdata_r[`SPH_ST_OVF]));
      amatch_r <= (is_client && char_done && addr_ph_r && rx_char == addr_r) |
                  (amatch_r & ~(clr_st & wdata_r[`SPH_ST_AMATCH]));
      sschg_r <= (is_client && ss_in != ss_q_r) |
                 (sschg_r & ~(clr_st & wdata_r[`SPH_ST_SSCHG]));
    end
  end

  // host sequencer, divider and shared shift path
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= sph_pkg::SPH_IDLE; div_cnt_r <= 8'h00; edge_cnt_r <= 4'h0;
      sck_r <= 1'b0; ss_auto_r <= 1'b1; tx_sh_r <= 8'h00; rx_sh_r <= 8'h00;
    end else begin
      // RQ5 bit order on transmit
      if (load_ev) tx_sh_r <= tx_valid_r ? (lsb_r ? rev8(tx_buf_r) : tx_buf_r) : 8'h00;
      else if (stp) tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      if (smp) rx_sh_r <= {rx_sh_r[6:0], din};
      if (edge_ev) edge_cnt_r <= edge_cnt_r + 4'h1;
      else if ((is_client && ss_in) || state_r == sph_pkg::SPH_IDLE) edge_cnt_r <= 4'h0;
      // RQ7 divider gives half periods of baud+1 cycles
      if (state_r == sph_pkg::SPH_IDLE || !is_host) div_cnt_r <= 8'h00;
      else div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
      case (state_r)
        sph_pkg::SPH_IDLE: begin
          sck_r <= clock_polarity_select_r;
          ss_auto_r <= 1'b1;
          // RQ8 select lowered for the frame
          if (host_start) begin
            state_r <= sph_pkg::SPH_SHIFT;
            ss_auto_r <= 1'b0;
          end
        end
        sph_pkg::SPH_SHIFT: begin
          if (host_edge) sck_r <= ~sck_r;
          if (!is_host) state_r <= sph_pkg::SPH_IDLE;
          else if (char_done && !tx_valid_r) state_r <= sph_pkg::SPH_DONE;
        end
        sph_pkg::SPH_DONE: begin
          if (!is_host || tick) state_r <= sph_pkg::SPH_IDLE;
        end
        default: state_r <= sph_pkg::SPH_IDLE;
      endcase
    end
  end
  // RQ6 divider zero toggles each cycle, which is exactly half rate;
  // any larger divider must hold each half two cycles or more
  AST_SCK_HALF: assert property (                                          // RQ6
    is_host && baud_r != 8'h00 && $changed(sck_r) |=> $stable(sck_r))
    else $error("serial clock faster than the divider allows");
  // RQ8 select low throughout a host frame
  AST_SS_AUTO: assert property (state_r == sph_pkg::SPH_SHIFT |-> !ss_auto_r) // RQ8
    else $error("automatic select high during frame");
  // RQ20 a host character does not end in the eight cycles after its start
  sequence s_frame_start;
    is_host && host_start;
  endsequence
  sequence s_no_end;
    !char_done [*8];
  endsequence
  AST_CHAR_EDGES: assert property (s_frame_start |=> s_no_end)             // RQ20
    else $error("character ended before sixteen edges");

  // client sampling of pin clock and select
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sck_q_r <= 1'b0; ss_q_r <= 1'b1; addr_ph_r <= 1'b0; drop_r <= 1'b0;
    end else begin
      sck_q_r <= sck_in;
      ss_q_r  <= ss_in;
      // RQ9 first character compared with address
      if (ss_fall) begin
        addr_ph_r <= amen; drop_r <= 1'b0;
      end else if (is_client && char_done && addr_ph_r) begin
        addr_ph_r <= 1'b0; drop_r <= rx_char != addr_r;
      end
    end
  end

  // pad drive by role; unselected pads float
  // RQ1 four wires, both directions
  always_comb begin
    pad_o_nxt  = 4'h0;
    pad_oe_nxt = 4'h0;
    // RQ12 host drives data, clock and select
    if (is_host) begin
      pad_o_nxt[do_pad]   = tx_sh_r[7];
      // RQ4 data-out released when unused
      pad_oe_nxt[do_pad]  = !txdis;
      pad_o_nxt[sck_pad]  = sck_r;
      pad_oe_nxt[sck_pad] = 1'b1;
      pad_o_nxt[ss_pad]   = ss_lvl;
      pad_oe_nxt[ss_pad]  = 1'b1;
    // RQ12 client drives data only while selected
    end else if (is_client && !ss_in) begin
      pad_o_nxt[do_pad]   = tx_sh_r[7];
      pad_oe_nxt[do_pad]  = !txdis;
    end
  end

  // registered pads, wake and dma requests
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PAD_O <= 4'h0; PAD_OE_O <= 4'h0; WAKE_O <= 1'b0;
      DMA_TX_REQ_O <= 1'b0; DMA_RX_REQ_O <= 1'b0;
    end else begin
      PAD_O    <= pad_o_nxt;
      PAD_OE_O <= pad_oe_nxt;
      // RQ11 RQ15 select change or received char wakes
      WAKE_O <= (is_client && ss_in != ss_q_r) || (SLEEP_I && push);
      // RQ17 dma requests from buffer state
      DMA_TX_REQ_O <= en_r && !tx_valid_r;
      DMA_RX_REQ_O <= rx_cnt_r != '0;
    end
  end
  AST_DO_RELEASE: assert property (txdis |=> !PAD_OE_O[$past(do_pad)])    // RQ4
    else $error("data-out pad driven while released");
  AST_HOST_PINS: assert property (is_host |=> PAD_OE_O[$past(sck_pad)] && // RQ12
    PAD_OE_O[$past(ss_pad)])
    else $error("host clock or select pad not driven");
  AST_WAKE: assert property (is_client && ss_in != ss_q_r |=> WAKE_O)     // RQ11
    else $error("no wake on select change");
  AST_DMA_RX: assert property (rx_cnt_r != '0 |=> DMA_RX_REQ_O)           // RQ17
    else $error("receive dma request missing");

endmodule // sph_top

// *** verif/sph_client_model.sv ***
// behavioural serial client on the far side of the host link
// assumes pad levels already resolved by the bench; select frames each transfer
`timescale 1ns/1ps
module sph_client_model (
  input  wire logic       sck_i,
  input  wire logic       sel_n_i,
  input  wire logic       mosi_i,
  input  wire logic       clock_polarity_select_i,
  input  wire logic       clock_phase_select_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  logic [7:0] tx_q;
  logic       first_q;
  initial begin
    tx_q = 8'h00;
    first_q = 1'b0;
    got_o = 8'h00;
  end
  always @(negedge sel_n_i) begin
    tx_q = reply_i;
    first_q = clock_phase_select_i;
    got_o = 8'h00;
  end
  // sample on one edge, launch on the other
  always @(sck_i) begin
    if (!sel_n_i) begin
      if (sck_i == !(clock_polarity_select_i ^ clock_phase_select_i)) got_o = {got_o[6:0], mosi_i};
      else if (first_q) first_q = 1'b0; // phase 1: leading edge shows msb
      else tx_q = {tx_q[6:0], 1'b0};
    end
  end
  // unselected line shows the inverse, so stale data never matches
  always_comb miso_o = sel_n_i ? ~tx_q[7] : tx_q[7];
endmodule // sph_client_model

// *** verif/sph_top_tb.sv ***
// self-checking bench: axi4-lite master, host role against a client model
// assumes pad layout 0 (out p0, clock p1, select p2) and data-in on pad 3
`timescale 1ns/1ps
`include "sph_regs.svh"
module sph_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, miso, wake, dtx, drx;
  logic        clock_polarity_select = 1'b0, clock_phase_select = 1'b0;
  logic [1:0]  bresp, rresp, rd_r;
  logic [31:0] rdata, rd_d;
  logic [3:0]  pad_o, pad_oe, pad_lvl;
  logic [7:0]  reply = 8'h00, got;
  int          errors = 0, samples_checked = 0, cycles = 0;

  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  end
  // undriven host pads are pulled up; pad 3 carries the client answer
  always_comb for (int i = 0; i < 4; i++)
    pad_lvl[i] = pad_oe[i] ? pad_o[i] : (i == 3 ? miso : 1'b1);

  sph_top dut_u (.REF_CLK_I(clk), .NRST_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .PAD_I(pad_lvl), .PAD_O(pad_o), .PAD_OE_O(pad_oe),
    .SLEEP_I(1'b0), .WAKE_O(wake), .DMA_TX_REQ_O(dtx), .DMA_RX_REQ_O(drx));
  sph_client_model model_u (.sck_i(pad_lvl[1]), .sel_n_i(pad_lvl[2]), .mosi_i(pad_lvl[0]),
    .clock_polarity_select_i(clock_polarity_select), .clock_phase_select_i(clock_phase_select), .reply_i(reply), .miso_o(miso), .got_o(got));

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a hung handshake ends the run here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7-k];
  endfunction
  // readies are sampled at the falling edge so the rising edge acts on settled values
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, b_hit;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end while (!b_hit);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, r_hit;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hit = arvalid & arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
    end while (!r_hit);
    rready <= 1'b0;
  endtask
  task automatic wait_st(input int bitn, input logic val);
    logic [31:0] d;
    logic [1:0]  r;
    do axr(`SPH_OFS_STATUS, d, r); while (d[bitn] !== val);
  endtask
  // one host character in mode i[1:0]; round 4 is lsb first
  task automatic t_xfer(input int i, input logic [7:0] tx, input logic [7:0] rp);
    logic [31:0] d, ca;
    logic [1:0]  r;
    logic        lsb;
    lsb = (i == 4);
    ca = {20'h0, 4'h3, 1'b0, lsb, i[1], i[0], 4'hc};
    clock_polarity_select <= i[0];
    clock_phase_select <= i[1];
    reply <= rp;
    axw(`SPH_OFS_CTRLA, ca, r);
    axw(`SPH_OFS_CTRLA, ca | 32'h1, r);
    // the request register updates at the handshake edge; look half a cycle later
    @(negedge clk);
    chk({31'h0, dtx}, 32'h1);
    axw(`SPH_OFS_DATA, {24'h0, tx}, r);
    wait_st(2, 1'b1);
    chk({31'h0, drx}, 32'h1);
    axr(`SPH_OFS_DATA, d, r);
    chk(d & 32'hff, {24'h0, lsb ? rev(rp) : rp});
    chk({24'h0, got}, {24'h0, lsb ? rev(tx) : tx});
    @(negedge clk);
    chk({28'h0, pad_oe}, 32'h7);
    chk({31'h0, pad_lvl[2]}, 32'h1);
  endtask

  initial begin
    repeat (5) @(negedge clk);
    chk({28'h0, pad_oe}, 32'h0);
    @(posedge rst_n);
    axr(`SPH_OFS_CTRLB, rd_d, rd_r);
    chk(rd_d, 32'h10);
    axr(8'h18, rd_d, rd_r);
    chk({30'h0, rd_r}, {30'h0, `SPH_RESP_SLVERR});
    axw(`SPH_OFS_BAUD, 32'h1, rd_r);
    axw(`SPH_OFS_CTRLB, 32'h3, rd_r);
    wait_st(6, 1'b0);
    for (int i = 0; i < 5; i++) t_xfer(i, 8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
    // releasing data-out must free its pad while clock and select stay driven
    axw(`SPH_OFS_CTRLB, 32'hb, rd_r);
    chk({30'h0, rd_r}, {30'h0, `SPH_RESP_OKAY});
    wait_st(6, 1'b0);
    @(negedge clk);
    chk({28'h0, pad_oe}, 32'h6);
    conclude();
  end
endmodule // sph_top_tb
